// File: design/cwom_top.sv
// CAN controller low-power exit and overwrite receive mailbox with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module cwom_top #(
    parameter int RUN = cwom_pkg::RECESSIVE_RUN
) (
    input  wire logic                         I_SYS_CLK,
    input  wire logic                         I_SYS_RST,
    input  wire logic                         I_CLK_EN,
    // Wishbone classic slave
    input  wire logic                         I_WB_CYC,
    input  wire logic                         I_WB_STB,
    input  wire logic                         I_WB_WE,
    input  wire logic [cwom_pkg::ADR_W-1:0]   I_WB_ADR,
    input  wire logic [3:0]                   I_WB_SEL,
    input  wire logic [31:0]                  I_WB_DAT,
    output logic                              O_WB_ACK,
    output logic [31:0]                       O_WB_DAT,
    // Bus side
    input  wire logic                         I_CAN_RX,
    input  wire logic                         I_BIT_TICK,
    input  wire logic                         I_RX_VALID,
    input  wire logic [cwom_pkg::ID_W-1:0]    I_RX_ID,
    input  wire logic [31:0]                  I_RX_DATA_LO,
    input  wire logic [31:0]                  I_RX_DATA_HI,
    output logic                              O_TX_READY,
    output logic                              O_IRQ
);
    import cwom_pkg::*;

    // The resync counter is sized for at most 255 bits
    if (RUN < 1 || RUN > 255) begin : g_chk
        $error("cwom_top: RUN must be 1 to 255");
    end

    typedef struct packed {
        cwom_pwr_type     pwr;
        logic             lpr;
        logic             sleep;
        logic             wake;
        logic [EV_W-1:0]  imr;
        logic [EV_W-1:0]  isr;
        logic [1:0]       mailbox_object_type;
        logic [ID_W-1:0]  mb_id;
        logic [ID_W-1:0]  mb_mask;
        logic             rdy;
        logic             lost;
        logic [31:0]      dlo;
        logic [31:0]      dhi;
        logic             ack;
        logic [31:0]      rdat;
        logic             irq;
        logic             txrdy;
    } cwom_state_type;

    cwom_state_type s_reg;
    cwom_state_type s_next;
    logic           synced;
    logic           match;
    logic           accept;
    logic           overwrite;
    logic           bus_go;
    logic           wr_go;
    logic           rd_go;
    logic [7:0]     adr;
    logic [31:0]    wv;
    logic [31:0]    mot_wr;
    logic           msr_rd;

    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_sel

    function automatic logic is_rx_type(input logic [1:0] mailbox_object_type);
        return (mailbox_object_type == MOT_RX) || (mailbox_object_type == MOT_RX_OVR);
    endfunction : is_rx_type

    cwom_resync #(.RUN(RUN)) u_resync (
        .i_clk      (I_SYS_CLK),
        .i_rst      (I_SYS_RST),
        .i_ce       (I_CLK_EN),
        .i_hold     (s_reg.pwr != PWR_RESYNC),
        .i_bit_tick (I_BIT_TICK),
        .i_rx       (I_CAN_RX),
        .o_synced   (synced)
    );

    cwom_accept #(.ID_BITS(ID_W)) u_accept (
        .i_rx_id   (I_RX_ID),
        .i_mb_id   (s_reg.mb_id),
        .i_mb_mask (s_reg.mb_mask),
        .o_match   (match)
    );

    assign adr       = {I_WB_ADR[7:2], 2'b00};
    // Side effects happen on the edge where the master samples ack
    assign bus_go    = I_WB_CYC && I_WB_STB && s_reg.ack;
    assign wr_go     = bus_go && I_WB_WE;
    assign rd_go     = bus_go && !I_WB_WE;
    // Messages are only taken once the controller is back on the bus
    assign accept    = I_RX_VALID && (s_reg.pwr == PWR_ACTIVE) && is_rx_type(s_reg.mailbox_object_type) && match;
    assign overwrite = accept && s_reg.rdy;
    // Object type as it stands after a write to the mailbox mode register (OFS_MMR)
    assign mot_wr    = merge_sel(32'(s_reg.mailbox_object_type), I_WB_DAT, I_WB_SEL);
    assign msr_rd    = rd_go && (adr == OFS_MSR);

    always_comb begin
        s_next     = s_reg;
        wv         = 32'h0;
        s_next.ack = I_WB_CYC && I_WB_STB && !s_reg.ack;

        // Read data is captured when ack rises, unmapped offsets read zero
        if (s_next.ack && !I_WB_WE) begin
            case (adr)
                OFS_MODE:   s_next.rdat = 32'(s_reg.lpr) << MODE_LPR_BIT;
                OFS_STATUS: s_next.rdat = (32'(s_reg.sleep) << ST_SLEEP_BIT) | (32'(s_reg.wake) << ST_WAKE_BIT)
                                        | (32'(s_reg.txrdy) << ST_TXRDY_BIT);
                OFS_IMR:    s_next.rdat = 32'(s_reg.imr);
                OFS_ISR:    s_next.rdat = 32'(s_reg.isr);
                OFS_MMR:    s_next.rdat = 32'(s_reg.mailbox_object_type);
                OFS_MID:    s_next.rdat = 32'(s_reg.mb_id);
                OFS_MAM:    s_next.rdat = 32'(s_reg.mb_mask);
                OFS_MSR:    s_next.rdat = (32'(s_reg.rdy) << MSR_RDY_BIT) | (32'(s_reg.lost) << MSR_LOST_BIT);
                OFS_MDL:    s_next.rdat = s_reg.dlo;
                OFS_MDH:    s_next.rdat = s_reg.dhi;
                default:    s_next.rdat = 32'h0;
            endcase
        end

        // Low-power entry and exit
        case (s_reg.pwr)
            PWR_ACTIVE: begin
                if (s_reg.lpr) begin
                    s_next.pwr   = PWR_SLEEP;
                    s_next.sleep = 1'b1;
                    s_next.wake  = 1'b0;
                end
            end
            PWR_SLEEP: begin
                if (!s_reg.lpr) begin
                    s_next.pwr = PWR_RESYNC;
                end
            end
            PWR_RESYNC: begin
                if (s_reg.lpr) begin
                    s_next.pwr   = PWR_SLEEP;
                    s_next.sleep = 1'b1;
                    s_next.wake  = 1'b0;
                end else if (synced) begin
                    s_next.pwr   = PWR_ACTIVE;
                    s_next.wake  = 1'b1;
                    s_next.sleep = 1'b0;
                end
            end
            default: s_next.pwr = PWR_ACTIVE;
        endcase

        // Reading mailbox status clears the lost flag; a new overwrite below still wins
        if (rd_go && adr == OFS_MSR) begin
            s_next.lost = 1'b0;
        end

        if (wr_go) begin
            case (adr)
                OFS_MODE: begin
                    wv         = merge_sel(32'(s_reg.lpr), I_WB_DAT, I_WB_SEL);
                    s_next.lpr = wv[MODE_LPR_BIT];
                end
                OFS_IMR: begin
                    wv         = merge_sel(32'(s_reg.imr), I_WB_DAT, I_WB_SEL);
                    s_next.imr = wv[EV_W-1:0];
                end
                OFS_ISR:  s_next.isr = s_reg.isr & ~(I_WB_DAT[EV_W-1:0] & {EV_W{I_WB_SEL[0]}});
                OFS_MMR: begin
                    s_next.mailbox_object_type = mot_wr[1:0];
                    if (is_rx_type(s_next.mailbox_object_type)) begin
                        s_next.rdy  = 1'b0;
                        s_next.lost = 1'b0;
                    end
                end
                OFS_MID: begin
                    wv           = merge_sel(32'(s_reg.mb_id), I_WB_DAT, I_WB_SEL);
                    s_next.mb_id = wv[ID_W-1:0];
                end
                OFS_MAM: begin
                    wv             = merge_sel(32'(s_reg.mb_mask), I_WB_DAT, I_WB_SEL);
                    s_next.mb_mask = wv[ID_W-1:0];
                end
                OFS_MCR: begin
                    if (I_WB_SEL[0] && I_WB_DAT[MCR_RELEASE_BIT]) begin
                        s_next.rdy = 1'b0;
                    end
                end
                default: s_next.mailbox_object_type = s_next.mailbox_object_type;
            endcase
        end

        // Mailbox reception
        if (accept) begin
            if (!s_reg.rdy || s_reg.mailbox_object_type == MOT_RX_OVR) begin
                s_next.dlo = I_RX_DATA_LO;
                s_next.dhi = I_RX_DATA_HI;
            end
            s_next.rdy = 1'b1;
            if (s_reg.rdy) begin
                s_next.lost = 1'b1;
            end
        end

        // Sticky events: a level flag keeps its bit set while it stands
        s_next.isr[EV_MBX_BIT]  = s_next.isr[EV_MBX_BIT] | s_next.rdy;
        s_next.isr[EV_WAKE_BIT] = s_next.isr[EV_WAKE_BIT] | s_next.wake;
        s_next.isr[EV_LOST_BIT] = s_next.isr[EV_LOST_BIT] | overwrite;
        s_next.irq   = |(s_next.isr & s_next.imr);
        s_next.txrdy = (s_next.pwr == PWR_ACTIVE) && !s_next.lpr;
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            s_reg         <= '0;
            s_reg.pwr     <= PWR_ACTIVE;
            s_reg.imr     <= IMR_RST;
            s_reg.mb_mask <= MAM_RST;
            s_reg.mailbox_object_type     <= MOT_DISABLED;
            s_reg.txrdy   <= 1'b1;
        end else if (I_CLK_EN) begin
            s_reg <= s_next;
        end
    end

    assign O_WB_ACK   = s_reg.ack;
    assign O_WB_DAT   = s_reg.rdat;
    assign O_IRQ      = s_reg.irq;
    assign O_TX_READY = s_reg.txrdy;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    AST_WAKE_NEEDS_RUN: assert property ($rose(s_reg.wake) |-> $past(synced) && $past(s_reg.pwr) == PWR_RESYNC)
        else $error("wake flag set without recessive run");
    AST_WAKE_IRQ: assert property ((I_CLK_EN && s_reg.wake && s_next.imr[EV_WAKE_BIT]) |=> O_IRQ)
        else $error("masked-in wake flag gave no interrupt");
    AST_WAKE_CLEARS_SLEEP: assert property ($rose(s_reg.wake) |-> !s_reg.sleep)
        else $error("sleep flag still set after wake");
    AST_SLEEP_CLEARS_WAKE: assert property ($rose(s_reg.sleep) |-> !s_reg.wake)
        else $error("wake flag still set after sleep");
    AST_TX_AFTER_WAKE: assert property ($rose(O_TX_READY) |-> s_reg.wake && !s_reg.sleep)
        else $error("transmit allowed before resync");
    AST_DROP_WHILE_UNSYNCED: assert property ((I_CLK_EN && I_RX_VALID && s_reg.pwr != PWR_ACTIVE)
        |=> $stable(s_reg.dlo) && $stable(s_reg.rdy))
        else $error("frame taken while not synchronised");
    AST_ENABLE_CLEARS_RDY: assert property ((I_CLK_EN && wr_go && adr == OFS_MMR && !accept
        && is_rx_type(mot_wr[1:0])) |=> !s_reg.rdy)
        else $error("ready flag not cleared on receive enable");
    AST_FIRST_SETS_RDY: assert property ((I_CLK_EN && accept && !s_reg.rdy) |=> s_reg.rdy
        && s_reg.dlo == $past(I_RX_DATA_LO) && !$rose(s_reg.lost))
        else $error("first message did not set ready");
    AST_RDY_IRQ: assert property ((I_CLK_EN && s_reg.rdy && s_next.imr[EV_MBX_BIT]) |=> O_IRQ)
        else $error("ready mailbox interrupt not pending");
    AST_OVERWRITE: assert property ((I_CLK_EN && accept && s_reg.rdy && s_reg.mailbox_object_type == MOT_RX_OVR)
        |=> s_reg.dhi == $past(I_RX_DATA_HI) && s_reg.dlo == $past(I_RX_DATA_LO))
        else $error("overwrite did not replace stored message");
    AST_LOST_SET: assert property ((I_CLK_EN && overwrite) |=> s_reg.lost ##1 (s_reg.lost || $past(rd_go)))
        else $error("lost flag not set on overwrite");

    // Plain receive, filtering, power sequencing and register bus checks
    AST_TYPE1_KEEPS: assert property ((I_CLK_EN && accept && s_reg.rdy && s_reg.mailbox_object_type == MOT_RX)
        |=> $stable(s_reg.dlo) && $stable(s_reg.dhi) && s_reg.lost)
        else $error("plain receive mailbox overwrote its message");
    AST_LOST_READ_CLEAR: assert property ((I_CLK_EN && msr_rd && !overwrite) |=> !s_reg.lost)
        else $error("status read left lost flag set");
    AST_RDY_HELD_CLEAR: assert property ((I_CLK_EN && !s_reg.rdy && !accept) |=> !s_reg.rdy)
        else $error("ready flag set without a message");
    AST_FILTER_REJECT: assert property ((I_CLK_EN && I_RX_VALID && !match && !bus_go)
        |=> $stable(s_reg.rdy) && $stable(s_reg.dlo) && $stable(s_reg.lost))
        else $error("message failing the filter was stored");
    AST_SLEEP_ENTRY: assert property ((I_CLK_EN && s_reg.lpr && s_reg.pwr == PWR_ACTIVE)
        |=> s_reg.sleep && !s_reg.wake && s_reg.pwr == PWR_SLEEP)
        else $error("low-power request did not enter sleep");
    AST_NO_TX_OFF_BUS: assert property (s_reg.pwr != PWR_ACTIVE |-> !O_TX_READY)
        else $error("transmit ready while off the bus");
    AST_ACK_PULSE: assert property ((O_WB_ACK && I_CLK_EN) |=> !O_WB_ACK)
        else $error("bus ack held for two cycles");
    AST_GATED_FREEZE: assert property (!I_CLK_EN |=> $stable(s_reg))
        else $error("state moved while clock enable was low");
    AST_RESYNC_START: assert property ((I_CLK_EN && s_reg.pwr == PWR_SLEEP && !s_reg.lpr)
        |=> s_reg.pwr == PWR_RESYNC)
        else $error("clearing low-power request did not start resync");
    AST_MCR_RELEASE: assert property ((I_CLK_EN && wr_go && adr == OFS_MCR && I_WB_SEL[0]
        && I_WB_DAT[MCR_RELEASE_BIT] && !accept) |=> !s_reg.rdy)
        else $error("mailbox release left ready set");

    COV_WAKE_EXIT: cover property ($rose(s_reg.wake) ##[1:20] O_TX_READY);
    COV_OVERWRITE: cover property (overwrite && s_reg.mailbox_object_type == MOT_RX_OVR);
    COV_TYPE1_LOST: cover property (accept && s_reg.rdy && s_reg.mailbox_object_type == MOT_RX);
    COV_LOST_READ_CLEAR: cover property (s_reg.lost && rd_go && adr == OFS_MSR ##1 !s_reg.lost);
endmodule : cwom_top
`default_nettype wire

// File: design/cwom_pkg.sv
// Constants, register map and types for the CAN wake and overwrite mailbox block
// How it works
// - Eleven recessive bits resynchronise, then wake flag
// - Wake flag raises interrupt when mask enables
// - Wake flag setting clears low-power status flag
// - Low-power status setting clears wake flag
// - Transmit allowed in the same cycle the wake flag sets
// - Frame in progress is discarded until interframe
// - Object type field selects receive-with-overwrite mode
// - Enabling receive clears ready until first message
// - First accepted message sets mailbox ready flag
// - Ready flag keeps mailbox interrupt pending, masked
// - Later accepted message overwrites stored message
// - Overwrite sets lost flag; status read clears
// - Data registers may change during software reads
package cwom_pkg;
    localparam int          ADR_W            = 8;
    localparam int          ID_W             = 29;
    localparam int          RECESSIVE_RUN    = 11;
    // Register byte offsets
    localparam logic [7:0]  OFS_MODE         = 8'h00;
    localparam logic [7:0]  OFS_STATUS       = 8'h04;
    localparam logic [7:0]  OFS_IMR          = 8'h08;
    localparam logic [7:0]  OFS_ISR          = 8'h0c;
    localparam logic [7:0]  OFS_MMR          = 8'h10;
    localparam logic [7:0]  OFS_MID          = 8'h14;
    localparam logic [7:0]  OFS_MAM          = 8'h18;
    localparam logic [7:0]  OFS_MSR          = 8'h1c;
    localparam logic [7:0]  OFS_MDL          = 8'h20;
    localparam logic [7:0]  OFS_MDH          = 8'h24;
    localparam logic [7:0]  OFS_MCR          = 8'h28;
    // Field positions
    localparam int          MODE_LPR_BIT     = 0;
    localparam int          ST_SLEEP_BIT     = 0;
    localparam int          ST_WAKE_BIT      = 1;
    localparam int          ST_TXRDY_BIT     = 2;
    localparam int          EV_MBX_BIT       = 0;
    localparam int          EV_WAKE_BIT      = 1;
    localparam int          EV_LOST_BIT      = 2;
    localparam int          EV_W             = 3;
    localparam int          MSR_RDY_BIT      = 0;
    localparam int          MSR_LOST_BIT     = 1;
    localparam int          MCR_RELEASE_BIT  = 0;
    // Mailbox object types
    localparam logic [1:0]  MOT_DISABLED     = 2'h0;
    localparam logic [1:0]  MOT_RX           = 2'h1;
    localparam logic [1:0]  MOT_RX_OVR       = 2'h2;
    // Reset values
    localparam logic [EV_W-1:0] IMR_RST      = 3'h0;
    localparam logic [ID_W-1:0] MAM_RST      = 29'h1fffffff;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_RESYNC} cwom_pwr_type;
endpackage : cwom_pkg

// File: design/cwom_accept.sv
// Acceptance filter: compares an identifier against mailbox identifier and mask
`timescale 1ns/1ps
`default_nettype none
module cwom_accept #(
    parameter int ID_BITS = cwom_pkg::ID_W
) (
    input  wire logic [ID_BITS-1:0] i_rx_id,
    input  wire logic [ID_BITS-1:0] i_mb_id,
    input  wire logic [ID_BITS-1:0] i_mb_mask,
    output logic                    o_match
);
    import cwom_pkg::*;

    if (ID_BITS < 1 || ID_BITS > 29) begin : g_chk
        $error("cwom_accept: ID_BITS must be 1 to 29");
    end

    // A cleared mask bit makes that identifier bit a don't-care
    always_comb begin
        o_match = ((i_rx_id ^ i_mb_id) & i_mb_mask) == '0;
    end
endmodule : cwom_accept
`default_nettype wire

// File: design/cwom_resync.sv
// Bus resynchroniser: counts consecutive recessive bits after low power ends
`timescale 1ns/1ps
`default_nettype none
module cwom_resync #(
    parameter int RUN = cwom_pkg::RECESSIVE_RUN
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_hold,
    input  wire logic i_bit_tick,
    input  wire logic i_rx,
    output logic      o_synced
);
    import cwom_pkg::*;

    localparam int CW = $clog2(RUN + 1);

    if (RUN < 1 || RUN > 255) begin : g_chk
        $error("cwom_resync: RUN must be 1 to 255");
    end

    typedef struct packed {
        logic [CW-1:0] run;
    } cwom_rsync_type;

    cwom_rsync_type s_reg;
    cwom_rsync_type s_next;

    // A dominant bit restarts the count until the run completes, so a frame in flight is waited out
    always_comb begin
        s_next = s_reg;
        if (i_hold) begin
            s_next.run = '0;
        end else if (i_bit_tick && s_reg.run != CW'(RUN)) begin
            s_next.run = i_rx ? s_reg.run + CW'(1) : '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_synced = (s_reg.run == CW'(RUN));

    AST_DOMINANT_RESTARTS: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_hold && i_bit_tick && !i_rx && !o_synced) |=> !o_synced)
        else $error("dominant bit did not restart resync count");
    COV_SYNC_REACHED: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_synced));
endmodule : cwom_resync
`default_nettype wire

// File: tb/cwom_bus_node.sv
// Model of the other CAN nodes: bit sample ticks, bus level and accepted frames
`timescale 1ns/1ps
`default_nettype none
module cwom_bus_node #(
    parameter int BIT_CYC = 4
) (
    input  wire logic                 i_clk,
    output logic                      o_can_rx,
    output logic                      o_bit_tick,
    output logic                      o_rx_valid,
    output logic [cwom_pkg::ID_W-1:0] o_rx_id,
    output logic [31:0]               o_data_lo,
    output logic [31:0]               o_data_hi
);
    import cwom_pkg::*;
    initial begin
        o_can_rx   = 1'b1;
        o_bit_tick = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_id    = '0;
        o_data_lo  = '0;
        o_data_hi  = '0;
    end
    // Bus activity only; waking the controller is left to software
    task automatic send_bits(input logic lvl, input int n);
        repeat (n) begin
            o_can_rx <= lvl;
            repeat (BIT_CYC - 1) @(posedge i_clk);
            o_bit_tick <= 1'b1;
            @(posedge i_clk);
            o_bit_tick <= 1'b0;
        end
    endtask : send_bits
    // Frame fields go stale right after the valid cycle
    task automatic send_msg(input logic [ID_W-1:0] id, input logic [31:0] lo, input logic [31:0] hi);
        o_rx_valid <= 1'b1;
        o_rx_id    <= id;
        o_data_lo  <= lo;
        o_data_hi  <= hi;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_id    <= ~id;
        o_data_lo  <= ~lo;
        o_data_hi  <= ~hi;
        @(posedge i_clk);
    endtask : send_msg
endmodule : cwom_bus_node
`default_nettype wire

// File: tb/cwom_top_tb.sv
// Self-checking bench for the CAN wake and overwrite mailbox block
`timescale 1ns/1ps
`default_nettype none
module cwom_top_tb;
    import cwom_pkg::*;
    localparam int RUN_T = 2;
    logic            clk;
    logic            rst;
    logic            clk_en;
    logic            cyc;
    logic            stb;
    logic            we;
    logic [7:0]      adr;
    logic [3:0]      sel;
    logic [31:0]     wdat;
    logic            ack;
    logic [31:0]     rdat;
    logic            can_rx;
    logic            tick;
    logic            rxv;
    logic [ID_W-1:0] rx_id;
    logic [31:0]     lo;
    logic [31:0]     hi;
    logic            tx_ready;
    logic            irq;
    int              mismatches;
    int              comparisons;

    cwom_top #(.RUN(RUN_T)) DUT (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(clk_en),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
        .I_CAN_RX(can_rx), .I_BIT_TICK(tick), .I_RX_VALID(rxv), .I_RX_ID(rx_id),
        .I_RX_DATA_LO(lo), .I_RX_DATA_HI(hi), .O_TX_READY(tx_ready), .O_IRQ(irq)
    );
    cwom_bus_node #(.BIT_CYC(4)) u_node (
        .i_clk(clk), .o_can_rx(can_rx), .o_bit_tick(tick), .o_rx_valid(rxv),
        .o_rx_id(rx_id), .o_data_lo(lo), .o_data_hi(hi)
    );

    always #50 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Classic single cycle: hold until ack is sampled, then idle one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask : rd

    task automatic reset_values;
        rd("status", OFS_STATUS, 32'h4);
        rd("accept mask", OFS_MAM, 32'h1fffffff);
        wr(8'h3c, 32'hffffffff);
        rd("unmapped", 8'h3c, 32'h0);
    endtask : reset_values

    task automatic wake_exit;
        wr(OFS_MID, 32'h123);
        wr(OFS_MMR, {30'h0, MOT_RX_OVR});
        wr(OFS_IMR, 32'h2);
        wr(OFS_MODE, 32'h1);
        rd("status asleep", OFS_STATUS, 32'h1);
        chk("tx asleep", {31'h0, tx_ready}, 32'h0);
        u_node.send_msg(29'h123, 32'h0badf00d, 32'h0);
        // Clock is gated while asleep and restored before the request is cleared
        clk_en <= 1'b0;
        repeat (4) @(posedge clk);
        chk("tx gated asleep", {31'h0, tx_ready}, 32'h0);
        clk_en <= 1'b1;
        wr(OFS_MODE, 32'h0);
        u_node.send_bits(1'b0, 1);
        u_node.send_msg(29'h123, 32'haaaa5555, 32'h5555aaaa);
        u_node.send_bits(1'b1, RUN_T - 1);
        u_node.send_bits(1'b0, 1);
        u_node.send_bits(1'b1, RUN_T - 1);
        repeat (2) @(posedge clk);
        chk("tx early", {31'h0, tx_ready}, 32'h0);
        // A recessive bit seen while the clock is gated must not count
        clk_en <= 1'b0;
        u_node.send_bits(1'b1, 1);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        chk("tx gated resync", {31'h0, tx_ready}, 32'h0);
        u_node.send_bits(1'b1, 1);
        repeat (2) @(posedge clk);
        chk("tx awake", {31'h0, tx_ready}, 32'h1);
        rd("status awake", OFS_STATUS, 32'h6);
        chk("wake irq", {31'h0, irq}, 32'h1);
        rd("msr after resync", OFS_MSR, 32'h0);
        wr(OFS_IMR, 32'h0);
        repeat (2) @(posedge clk);
        chk("wake irq masked", {31'h0, irq}, 32'h0);
    endtask : wake_exit

    task automatic receive_overwrite;
        wr(OFS_IMR, 32'h1);
        u_node.send_msg(29'h124, 32'h1, 32'h2);
        rd("msr filtered", OFS_MSR, 32'h0);
        u_node.send_msg(29'h123, 32'h11111111, 32'h22222222);
        rd("msr first", OFS_MSR, 32'h1);
        rd("mdl first", OFS_MDL, 32'h11111111);
        chk("mailbox irq", {31'h0, irq}, 32'h1);
        u_node.send_msg(29'h123, 32'h33333333, 32'h44444444);
        u_node.send_msg(29'h123, 32'h55555555, 32'h66666666);
        rd("msr lost", OFS_MSR, 32'h3);
        rd("mdl latest", OFS_MDL, 32'h55555555);
        rd("mdh latest", OFS_MDH, 32'h66666666);
        rd("msr read clear", OFS_MSR, 32'h1);
        rd("isr", OFS_ISR, 32'h7);
        // A message lands between the two data reads, so the words must be read again
        rd("mdl torn", OFS_MDL, 32'h55555555);
        u_node.send_msg(29'h123, 32'habcdef01, 32'h10fedcba);
        rd("mdh torn", OFS_MDH, 32'h10fedcba);
        rd("msr set again", OFS_MSR, 32'h3);
        rd("mdl reread", OFS_MDL, 32'habcdef01);
        rd("mdh reread", OFS_MDH, 32'h10fedcba);
        wr(OFS_MCR, 32'h1);
        wr(OFS_ISR, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq released", {31'h0, irq}, 32'h0);
        rd("isr after clear", OFS_ISR, 32'h2);
        wr(OFS_MMR, {30'h0, MOT_RX});
        u_node.send_msg(29'h123, 32'h77777777, 32'h0);
        u_node.send_msg(29'h123, 32'h88888888, 32'h0);
        rd("msr plain", OFS_MSR, 32'h3);
        rd("mdl kept", OFS_MDL, 32'h77777777);
        wr(OFS_MMR, {30'h0, MOT_RX_OVR});
        rd("msr re-enabled", OFS_MSR, 32'h0);
        u_node.send_msg(29'h123, 32'h99999999, 32'h0);
        rd("mdl overwrite", OFS_MDL, 32'h99999999);
        wr(OFS_MODE, 32'h1);
        rd("status resleep", OFS_STATUS, 32'h1);
    endtask : receive_overwrite

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        clk_en      = 1'b1;
        cyc         = 1'b0;
        stb         = 1'b0;
        we          = 1'b0;
        adr         = 8'h0;
        sel         = 4'h0;
        wdat        = 32'h0;
        mismatches  = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reset_values();
        wake_exit();
        receive_overwrite();
        complete_run();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule : cwom_top_tb
`default_nettype wire
